// File: rtl/rbpc_pkg.sv
// constants shared by the registered buffer with parity check
package rbpc_pkg;

  // ----------------------------------------------------------------
  // data path widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 28;
  localparam int HOLD_W = 2;

  // ----------------------------------------------------------------
  // covered bits per layout (bit n sits at index n-1)
  // ----------------------------------------------------------------
  localparam logic [27:0] COVER_A_MASK = 28'hFFF0F5F;
  localparam logic [27:0] COVER_B_MASK = 28'hFAF0FFF;

  // ----------------------------------------------------------------
  // rank select positions within the input word, per layout
  // ----------------------------------------------------------------
  localparam int A_SEL0_IDX = 13;
  localparam int A_SEL1_IDX = 12;
  localparam int B_SEL0_IDX = 14;
  localparam int B_SEL1_IDX = 15;

  // ----------------------------------------------------------------
  // reset and reset values
  // ----------------------------------------------------------------
  localparam logic [27:0] DATA_RST = 28'h0000000;
  localparam logic ERR_LVL_RST = 1'b1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  // receiver wake-up time after reset release
  localparam int RX_EN_NS = 100;
  localparam int RX_EN_CYC_RAW =
    (RX_EN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RX_EN_CYC = (RX_EN_CYC_RAW < 1) ? 1 : RX_EN_CYC_RAW;
  localparam logic [3:0] RX_EN_CNT = 4'(RX_EN_CYC);
  // error flag least low time, in clock cycles
  localparam int ERR_HOLD_CYC = 2;
  localparam logic [1:0] HOLD_AFTER_ERR = 2'(ERR_HOLD_CYC - 1);
  localparam logic [1:0] HOLD_AFTER_LPM = 2'(ERR_HOLD_CYC);

endpackage

// File: rtl/rbpc_sync.sv
// two-stage synchroniser for static straps and reset release
`timescale 1ns/1ps
module rbpc_sync
  import rbpc_pkg::*;
#(
  parameter int W = 1
) (
  // clock and resets
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic arst_n_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // ----------------------------------------------------------------
  // first stage feeds only the second stage
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else if (sys_rst_i) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= d_i;
      q_ff <= meta_ff;
    end
  end

  assign q_o = q_ff;

endmodule

// File: rtl/rbpc_parity.sv
// parity of the covered input bits for the selected layout
`timescale 1ns/1ps
module rbpc_parity
  import rbpc_pkg::*;
(
  // input word and layout
  input wire logic [DATA_W-1:0] data_i,
  input wire logic mode_i,
  // odd-count flag of covered bits
  output logic odd_o
);

  logic [DATA_W-1:0] mask_w;

  // ----------------------------------------------------------------
  // per-rank bits are simply absent from both masks
  // ----------------------------------------------------------------
  assign mask_w = mode_i ? COVER_B_MASK : COVER_A_MASK;
  assign odd_o = ^(data_i & mask_w);

endmodule

// File: rtl/rbpc_top.sv
// registered 28-bit 1:2 buffer with delayed even-parity check
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module rbpc_top
  import rbpc_pkg::*;
(
  // clock and resets
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic dev_reset_n_i,
  // straps
  input wire logic pinout_mode_i,
  input wire logic cs_gate_enable_i,
  // controller side
  input wire logic [DATA_W-1:0] buffered_inputs_i,
  input wire logic parity_in_i,
  // dram side
  output logic [DATA_W-1:0] buffered_outputs_a_o,
  output logic [DATA_W-1:0] buffered_outputs_b_o,
  // open-drain error flag
  output logic parity_error_n_o,
  output logic parity_error_n_oe_o,
  // status
  output logic low_power_mode_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0] strap_s;
  logic mode_s;
  logic gate_en_s;
  logic rx_rel_s;
  logic [3:0] rx_cnt_ff;
  logic rx_on_ff;
  logic [DATA_W-1:0] q_a_ff;
  logic [DATA_W-1:0] q_b_ff;
  logic par_d_ff;
  logic vld_d_ff;
  logic err_ff;
  logic lvl_ff;
  logic oe_ff;
  logic [HOLD_W-1:0] hold_ff;
  logic lpm_ff;
  logic odd_w;
  logic sel0_n_w;
  logic sel1_n_w;
  logic rank_idle_w;
  logic gate_q_w;
  logic cap_w;
  logic load_q_w;
  logic par_bad_w;
  logic rst_w;
  logic [HOLD_W-1:0] nxt_hold;
  logic nxt_lvl;

  // ----------------------------------------------------------------
  // straps and reset release
  // ----------------------------------------------------------------
  // the layout strap is static; a change mid-run only moves the
  // covered set and the rank select positions at the next synchronised edge
  rbpc_sync #(.W(2)) u_strap_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .arst_n_i(dev_reset_n_i),
    .d_i({cs_gate_enable_i, pinout_mode_i}),
    .q_o(strap_s)
  );

  // release of the pin reset is brought in through two stages
  rbpc_sync #(.W(1)) u_rel_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .arst_n_i(dev_reset_n_i),
    .d_i(1'b1),
    .q_o(rx_rel_s)
  );

  assign mode_s = strap_s[0];
  assign gate_en_s = strap_s[1];
  assign rst_w = sys_rst_i || !dev_reset_n_i;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign sel0_n_w = mode_s ? buffered_inputs_i[B_SEL0_IDX]
                           : buffered_inputs_i[A_SEL0_IDX];
  assign sel1_n_w = mode_s ? buffered_inputs_i[B_SEL1_IDX]
                           : buffered_inputs_i[A_SEL1_IDX];
  // receivers off means no select is trusted yet
  assign rank_idle_w = rx_on_ff && sel0_n_w && sel1_n_w;
  assign gate_q_w = gate_en_s && rank_idle_w;
  assign cap_w = rx_on_ff;
  assign load_q_w = cap_w && !gate_q_w;
  assign par_bad_w = vld_d_ff && (par_d_ff ^ parity_in_i);

  rbpc_parity u_parity (
    .data_i(buffered_inputs_i),
    .mode_i(mode_s),
    .odd_o(odd_w)
  );

  // ----------------------------------------------------------------
  // receiver enable delay
  // ----------------------------------------------------------------
  // holds the register cleared for a short time after release so
  // outputs cannot glitch while receivers settle
  always_ff @(posedge sys_clk_i or negedge dev_reset_n_i) begin
    if (!dev_reset_n_i) begin
      rx_cnt_ff <= RX_EN_CNT;
      rx_on_ff <= 1'b0;
    end else if (sys_rst_i) begin
      rx_cnt_ff <= RX_EN_CNT;
      rx_on_ff <= 1'b0;
    end else if (rx_rel_s && !rx_on_ff) begin
      rx_cnt_ff <= rx_cnt_ff - 4'h1;
      rx_on_ff <= (rx_cnt_ff == 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // data register, duplicated onto both banks
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge dev_reset_n_i) begin
    if (!dev_reset_n_i) begin
      q_a_ff <= DATA_RST;
      q_b_ff <= DATA_RST;
    end else if (sys_rst_i) begin
      q_a_ff <= DATA_RST;
      q_b_ff <= DATA_RST;
    end else if (load_q_w) begin
      q_a_ff <= buffered_inputs_i;
      q_b_ff <= buffered_inputs_i;
    end
  end

  // ----------------------------------------------------------------
  // parity pipeline
  // ----------------------------------------------------------------
  // stage 1 keeps the covered-bit parity of the word just taken;
  // stage 2 folds in the late parity bit one cycle later
  always_ff @(posedge sys_clk_i or negedge dev_reset_n_i) begin
    if (!dev_reset_n_i) begin
      par_d_ff <= 1'b0;
      vld_d_ff <= 1'b0;
      err_ff <= 1'b0;
    end else if (sys_rst_i) begin
      par_d_ff <= 1'b0;
      vld_d_ff <= 1'b0;
      err_ff <= 1'b0;
    end else begin
      par_d_ff <= odd_w;
      vld_d_ff <= cap_w;
      err_ff <= par_bad_w;
    end
  end

  // ----------------------------------------------------------------
  // error flag hold logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_lvl = lvl_ff;
    nxt_hold = hold_ff;
    if (rank_idle_w) begin
      // frozen; a low flag owes two more cycles after wake-up
      if (!lvl_ff) begin
        nxt_hold = HOLD_AFTER_LPM;
      end
    end else if (err_ff) begin
      nxt_lvl = 1'b0;
      nxt_hold = HOLD_AFTER_ERR;
    end else if (hold_ff != '0) begin
      nxt_lvl = 1'b0;
      nxt_hold = hold_ff - 2'h1;
    end else begin
      nxt_lvl = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge dev_reset_n_i) begin
    if (!dev_reset_n_i) begin
      lvl_ff <= ERR_LVL_RST;
      oe_ff <= 1'b0;
      hold_ff <= '0;
      lpm_ff <= 1'b0;
    end else if (sys_rst_i) begin
      lvl_ff <= ERR_LVL_RST;
      oe_ff <= 1'b0;
      hold_ff <= '0;
      lpm_ff <= 1'b0;
    end else begin
      lvl_ff <= nxt_lvl;
      oe_ff <= !nxt_lvl;
      hold_ff <= nxt_hold;
      lpm_ff <= rank_idle_w;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign buffered_outputs_a_o = q_a_ff;
  assign buffered_outputs_b_o = q_b_ff;
  assign parity_error_n_o = lvl_ff;
  assign parity_error_n_oe_o = oe_ff;
  assign low_power_mode_o = lpm_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_w);

  property p_dup;
    q_a_ff == q_b_ff;
  endproperty
  a_dup: assert property (p_dup)
    else $error("bank copies differ");

  property p_cap;
    load_q_w |=> q_a_ff == $past(buffered_inputs_i);
  endproperty
  a_cap: assert property (p_cap)
    else $error("word not captured");

  property p_freeze;
    (cap_w && gate_q_w) |=> $stable(q_a_ff);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("outputs changed while gated");

  property p_lat;
    (par_bad_w && !rank_idle_w) ##1 !rank_idle_w |=> !lvl_ff;
  endproperty
  a_lat: assert property (p_lat)
    else $error("error flag late");

  property p_min;
    $fell(lvl_ff) |=> !lvl_ff;
  endproperty
  a_min: assert property (p_min)
    else $error("error flag low for one cycle");

  property p_run;
    (err_ff && !rank_idle_w) ##1 (err_ff && !rank_idle_w) |=> !lvl_ff[*2];
  endproperty
  a_run: assert property (p_run)
    else $error("error run not held");

  property p_pfrz;
    rank_idle_w |=> $stable(lvl_ff);
  endproperty
  a_pfrz: assert property (p_pfrz)
    else $error("flag moved while ranks idle");

  property p_lpm;
    (rank_idle_w && !lvl_ff) ##1 !rank_idle_w[*2] |-> !lvl_ff;
  endproperty
  a_lpm: assert property (p_lpm)
    else $error("flag released too soon after low power");

  property p_oe;
    oe_ff == !lvl_ff;
  endproperty
  a_oe: assert property (p_oe)
    else $error("enable does not match flag");

  property p_rx;
    !rx_on_ff |-> (q_a_ff == DATA_RST) && lvl_ff;
  endproperty
  a_rx: assert property (p_rx)
    else $error("outputs active before receivers");

  property p_rst;
    @(posedge sys_clk_i) disable iff (!dev_reset_n_i)
      sys_rst_i |=> (q_a_ff == DATA_RST) && lvl_ff;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset did not clear outputs");

  // parity bit lands one edge after its word, result one edge later
  property p_even;
    cap_w |=> ##1 err_ff == ($past(odd_w, 2) ^ $past(parity_in_i));
  endproperty
  a_even: assert property (p_even)
    else $error("late parity not paired with its word");

  // with the gate strap low the selects never freeze the data
  property p_nogate;
    (cap_w && !gate_en_s) |=> q_a_ff == $past(buffered_inputs_i);
  endproperty
  a_nogate: assert property (p_nogate)
    else $error("data frozen without gate enable");

  property p_dupb;
    load_q_w |=> q_b_ff == $past(buffered_inputs_i);
  endproperty
  a_dupb: assert property (p_dupb)
    else $error("b bank missed a word");

  // hold count is at most two, so three quiet cycles must release
  property p_rel;
    (!rank_idle_w && !err_ff) [*3] |=> lvl_ff;
  endproperty
  a_rel: assert property (p_rel)
    else $error("flag outstayed the error run");

  property p_lpo;
    !rx_on_ff |-> !lpm_ff;
  endproperty
  a_lpo: assert property (p_lpo)
    else $error("low power shown before receivers");

  c_err: cover property ($fell(lvl_ff));
  c_run: cover property (err_ff ##1 err_ff ##1 err_ff);
  c_lpm: cover property ((rank_idle_w && !lvl_ff) ##1 !rank_idle_w);
  c_gate: cover property (cap_w && gate_q_w);

endmodule

// File: verif/rbpc_ctrl_model.sv
// controller-side model: data words and their delayed parity bit
`timescale 1ns/1ps
module rbpc_ctrl_model (
  // clock
  input wire logic clk_i,
  // word to send, parity fault request, covered-bit mask
  input wire logic [27:0] word_i,
  input wire logic bad_i,
  input wire logic [27:0] mask_i,
  // controller pins
  output logic [27:0] buffered_inputs_o,
  output logic parity_in_o
);
  logic par_ff;
  initial begin
    par_ff = 1'b0;
    parity_in_o = 1'b0;
  end
  // the word is on the pins in the cycle the bench gives it
  assign buffered_inputs_o = word_i;
  // parity of the word just taken; bad_i flips it on purpose
  always @(posedge clk_i) begin
    par_ff <= (^(word_i & mask_i)) ^ bad_i;
  end
  // launched off the falling edge so it is settled one edge later
  always @(negedge clk_i) begin
    parity_in_o <= par_ff;
  end
endmodule

// File: verif/registered_buffer_parity_check_tb.sv
// self-checking bench for the registered buffer with parity check
`timescale 1ns/1ps
module registered_buffer_parity_check_tb;
  import rbpc_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  localparam logic [27:0] MASK_LO = 28'hFFF0F5F;
  localparam logic [27:0] MASK_HI = 28'hFAF0FFF;
  // row bits: 29 flag level at this row's check, 28 fault, 27:0 word
  localparam logic [29:0] ROWS [20] = '{
    30'h20000000, 30'h2FFFFFFF, 30'h20000000, 30'h25555555,
    30'h3AAAAAAA, 30'h21111111, 30'h22222222, 30'h03131313,
    30'h10F00F0F, 30'h30F00F1F, 30'h30F00F2F, 30'h07654321,
    30'h00000000, 30'h10000001, 30'h00000002, 30'h30000003,
    30'h00000000, 30'h00000000, 30'h00000000, 30'h00000000};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dev_reset_n = 1'b1;
  logic pinout_mode = 1'b0;
  logic cs_gate = 1'b0;
  logic raw = 1'b0;
  logic bad = 1'b0;
  logic [27:0] word = 28'h0;
  logic [27:0] prev_w = 28'h0;
  logic [3:0] hist = 4'h0;
  logic [27:0] din;
  logic par;
  logic [27:0] qa;
  logic [27:0] qb;
  logic parity_error_n_n;
  logic parity_error_n_oe;
  logic low_power_mode;
  int n_mismatch = 0;
  int samples_checked = 0;
  wire [27:0] cov_mask = pinout_mode ? MASK_HI : MASK_LO;
  wire [27:0] mask = raw ? 28'h0 : cov_mask;
  // open-drain flag with its pull-up
  wire parity_error_n_wire = parity_error_n_oe ? 1'b0 : 1'b1;

  always #25 clk = ~clk;

  rbpc_top uut (.sys_clk_i(clk), .sys_rst_i(rst),
    .dev_reset_n_i(dev_reset_n), .pinout_mode_i(pinout_mode),
    .cs_gate_enable_i(cs_gate), .buffered_inputs_i(din),
    .parity_in_i(par), .buffered_outputs_a_o(qa),
    .buffered_outputs_b_o(qb), .parity_error_n_o(parity_error_n_n),
    .parity_error_n_oe_o(parity_error_n_oe), .low_power_mode_o(low_power_mode));

  rbpc_ctrl_model ctrl (.clk_i(clk), .word_i(word), .bad_i(bad),
    .mask_i(mask), .buffered_inputs_o(din), .parity_in_o(par));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // error of a word: injected fault, or whole parity dropped when raw
  task automatic drive(input logic [27:0] w, input logic b);
    logic e;
    e = b ^ (raw ? ^(w & cov_mask) : 1'b0);
    hist = {hist[2:0], e};
    prev_w = w;
    word = w;
    bad = b;
  endtask

  // flag after edge j is low when word j-2 or j-3 was in error
  task automatic step(input logic [27:0] w, input logic b);
    @(negedge clk);
    chk(qa, prev_w);
    chk(qb, prev_w);
    chk({27'h0, parity_error_n_wire}, {27'h0, ~(hist[2] | hist[3])});
    chk({27'h0, parity_error_n_n}, {27'h0, ~(hist[2] | hist[3])});
    drive(w, b);
  endtask

  task automatic run_rows();
    for (int i = 0; i < 20; i++) begin
      step(ROWS[i][27:0], ROWS[i][28]);
      chk({27'h0, parity_error_n_n}, {27'h0, ROWS[i][29]});
    end
  endtask

  // every bit alone with parity held at 0: flag only for covered bits
  task automatic sweep();
    raw = 1'b1;
    for (int i = 0; i < 28; i++) begin
      step(28'h1 << i, 1'b0);
      repeat (4) step(28'h0, 1'b0);
    end
    raw = 1'b0;
  endtask

  // the strap only moves while the pin reset is held
  task automatic pin_reset(input logic m);
    @(negedge clk);
    dev_reset_n = 1'b0;
    pinout_mode = m;
    word = 28'hFFFFFFF;
    #1;
    chk(qa, 28'h0);
    chk({27'h0, parity_error_n_wire}, 28'h1);
    repeat (5) begin
      @(negedge clk);
      chk(qa, 28'h0);
      chk(qb, 28'h0);
      chk({27'h0, parity_error_n_wire}, 28'h1);
    end
    word = 28'h0;
    dev_reset_n = 1'b1;
    hist = 4'h0;
    prev_w = 28'h0;
    repeat (6) step(28'h0, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (6) step(28'h0, 1'b0);
    run_rows();
    sweep();
    // gating: error just before the ranks go idle
    cs_gate = 1'b1;
    repeat (3) step(28'h0, 1'b0);
    step(28'h0000055, 1'b1);
    step(28'h00000AA, 1'b0);
    step(28'h0000123, 1'b0);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      chk(qa, 28'h0000123);
      chk(qb, 28'h0000123);
      chk({27'h0, parity_error_n_wire}, 28'h0);
      if (i > 0) chk({27'h0, low_power_mode}, 28'h1);
      word = 28'hFFFFFFF;
    end
    hist = 4'h0;
    @(negedge clk);
    drive(28'h0, 1'b0);
    @(negedge clk);
    chk({27'h0, parity_error_n_wire}, 28'h0);
    chk({27'h0, low_power_mode}, 28'h0);
    @(negedge clk);
    chk({27'h0, parity_error_n_wire}, 28'h0);
    repeat (3) @(negedge clk);
    step(28'h0002000, 1'b0);
    step(28'h0, 1'b0);
    cs_gate = 1'b0;
    // reset in mid-error, then the second layout
    step(28'h0000001, 1'b1);
    step(28'h0ABCDEF, 1'b0);
    step(28'h1234567, 1'b0);
    pin_reset(1'b1);
    sweep();
    run_rows();
    give_verdict();
  end

  // ----------------------------------------------------------------
  // watchdog: whole run is well under a thousand cycles
  // ----------------------------------------------------------------
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule
